// *** logic/hsq_pkg.sv ***
package hsq_pkg;

   // ----------------------------------------------------------------
   // timing
   // ----------------------------------------------------------------
   localparam int CLK_PERIOD_NS     = 5;
   localparam int INIT_TIME_MS      = 3;
   localparam int INIT_CYC          = INIT_TIME_MS * 1000000 / CLK_PERIOD_NS;
   localparam int CONFIG_TIMEOUT_MS = 95;
   localparam int CONFIG_CYC        =
      CONFIG_TIMEOUT_MS * 1000000 / CLK_PERIOD_NS;
   localparam int CONNECT_TIME_US   = 1;
   localparam int CONNECT_CYC       = CONNECT_TIME_US * 1000 / CLK_PERIOD_NS;
   localparam int REF_LOCK_EDGES    = 8;
   localparam int REF_LOSS_CYC      = 64;
   localparam int LINK_PERIOD_NS    = 160;
   localparam int REFCLK_HALF_CYC   = LINK_PERIOD_NS / 2 / CLK_PERIOD_NS;

   // ----------------------------------------------------------------
   // device register map
   // ----------------------------------------------------------------
   localparam int        CFG_COUNT      = 16;
   localparam logic[7:0] REG_CFG_BASE   = 8'h00;
   localparam logic[7:0] REG_INTERLOCK  = 8'hE7;
   localparam logic[7:0] REG_PORTABLE   = 8'hEE;
   localparam logic[7:0] REG_STAGE      = 8'hF0;
   localparam int        ILK_HOLD_BIT   = 0;
   localparam int        ILK_GO_BIT     = 1;
   localparam int        PORTABLE_HUB_CONFIG_WAIT_BIT  = 0;
   localparam int        PORTABLE_HUB_CONFIG_SINGLE_BIT = 1;
   localparam logic[7:0] PORTABLE_HUB_CONFIG_DEFAULT   = 8'h00;
   // identity-like defaults are arbitrary values
   localparam logic[7:0] ROM_SEED       = 8'hA5;

   // ----------------------------------------------------------------
   // translator buffer organisation
   // ----------------------------------------------------------------
   localparam int TT_PORTS          = 3;
   localparam int TT_SS_DESC_BYTES  = 256;
   localparam int TT_SS_DATA_BYTES  = 752;
   localparam int TT_CS_DESC_BYTES  = 128;
   localparam int TT_CS_DATA_BYTES  = 376;
   localparam int TT_NP_DESC_BYTES  = 16;
   localparam int TT_NP_DATA_BYTES  = 256;
   localparam int TT_NP_BUFFERS     = 4;
   localparam int TT_PERIODIC_BYTES = TT_SS_DESC_BYTES + TT_SS_DATA_BYTES
                                    + TT_CS_DESC_BYTES + TT_CS_DATA_BYTES;
   localparam int TT_NONPER_BYTES   = TT_NP_DESC_BYTES + TT_NP_DATA_BYTES;

   // ----------------------------------------------------------------
   // host register map (word addresses)
   // ----------------------------------------------------------------
   localparam logic[1:0] HST_CTRL      = 2'h0;
   localparam logic[1:0] HST_CMD       = 2'h1;
   localparam logic[1:0] HST_STAT      = 2'h2;
   localparam int        CTRL_RUN_BIT  = 0;
   localparam int        CTRL_STRAP_BIT = 1;
   localparam int        CTRL_CLK_BIT  = 2;
   localparam int        CTRL_ABORT_BIT = 3;
   localparam int        CMD_WE_BIT    = 16;

   typedef enum logic [2:0] {
      HSQ_STANDBY = 3'b000,
      HSQ_INIT    = 3'b001,
      HSQ_WAITREF = 3'b011,
      HSQ_CONFIG  = 3'b010,
      HSQ_CONNECT = 3'b110,
      HSQ_COMM    = 3'b111
   } hsq_stage_t;

   typedef enum logic [2:0] {
      HSQ_H_IDLE = 3'b000,
      HSQ_H_SETUP = 3'b001,
      HSQ_H_WAIT = 3'b011,
      HSQ_H_CAPT = 3'b010,
      HSQ_H_REL  = 3'b110
   } hsq_host_state_t;

endpackage

// *** logic/hsq_link_if.sv ***
`timescale 1ns/1ps
`default_nettype none
interface hsq_link_if;
   logic       reset_n;
   logic       refclk;
   logic       int_n_dev_oe;
   logic       int_n_host_oe;
   logic       int_n;
   logic       req;
   logic       we;
   logic [7:0] addr;
   logic [7:0] wdata;
   logic       ack;
   logic [7:0] rdata;

   // open-drain line with pull-up
   assign int_n = ~(int_n_dev_oe | int_n_host_oe);

   modport device (input reset_n, refclk, int_n, req, we, addr, wdata,
                   output int_n_dev_oe, ack, rdata);
   modport host   (input int_n, ack, rdata,
                   output reset_n, refclk, int_n_host_oe, req, we, addr,
                   wdata);
endinterface
`default_nettype wire

// *** logic/hsq_host.sv ***
`timescale 1ns/1ps
`default_nettype none
module hsq_host
   import hsq_pkg::*;
#(
   parameter int REFCLK_HALF = REFCLK_HALF_CYC
)(
   input  wire logic        clk_i,
   input  wire logic        rst_n_i,
   input  wire logic [1:0]  avs_address_i,
   input  wire logic        avs_read_i,
   input  wire logic        avs_write_i,
   input  wire logic [31:0] avs_writedata_i,
   output var  logic [31:0] avs_readdata_o,
   output var  logic        avs_waitrequest_o,
   hsq_link_if.host         link
);

   logic            ack_meta;
   logic            ack_s;
   logic [7:0]      rdata_meta;
   logic [7:0]      rdata_s;
   logic [3:0]      ctrl;
   logic [7:0]      div_cnt;
   logic            busy;
   logic            done;
   logic [7:0]      rdata;
   hsq_host_state_t hstate;
   logic            take;

   assign take = (avs_read_i | avs_write_i) & ~avs_waitrequest_o;

   // ----------------------------------------------------------------
   // pin synchronisers
   // ----------------------------------------------------------------
   always_ff @(posedge clk_i) begin
      if (!rst_n_i) begin
         ack_meta   <= 1'b0;
         ack_s      <= 1'b0;
         rdata_meta <= 8'h00;
         rdata_s    <= 8'h00;
      end else begin
         ack_meta   <= link.ack;
         ack_s      <= ack_meta;
         rdata_meta <= link.rdata;
         rdata_s    <= rdata_meta;
      end
   end

   // ----------------------------------------------------------------
   // avalon slave, one wait cycle per access
   // ----------------------------------------------------------------
   always_ff @(posedge clk_i) begin
      if (!rst_n_i) begin
         avs_waitrequest_o <= 1'b1;
         avs_readdata_o    <= 32'h0000_0000;
      end else if (take) begin
         avs_waitrequest_o <= 1'b1;
      end else if (avs_read_i | avs_write_i) begin
         avs_waitrequest_o <= 1'b0;
         case (avs_address_i)
            HST_CTRL: avs_readdata_o <= {28'h000_0000, 1'b0, ctrl[2:0]};
            HST_STAT: avs_readdata_o <= {16'h0000, rdata, 6'h00, done, busy};
            default:  avs_readdata_o <= 32'h0000_0000;
         endcase
      end
   end

   always_ff @(posedge clk_i) begin
      if (!rst_n_i) begin
         ctrl <= 4'h0;
      end else if (take && avs_write_i && avs_address_i == HST_CTRL) begin
         ctrl <= avs_writedata_i[3:0];
      end else begin
         ctrl[CTRL_ABORT_BIT] <= 1'b0;
      end
   end

   // ----------------------------------------------------------------
   // reset, strap and reference clock pins
   // ----------------------------------------------------------------
   always_ff @(posedge clk_i) begin
      if (!rst_n_i) begin
         link.reset_n       <= 1'b0;
         link.int_n_host_oe <= 1'b0;
      end else begin
         link.reset_n       <= ctrl[CTRL_RUN_BIT]; // [RULE_02]
         // software must hold it until the hub leaves init
         link.int_n_host_oe <= ctrl[CTRL_STRAP_BIT]; // [RULE_20]
      end
   end

   always_ff @(posedge clk_i) begin
      if (!rst_n_i || !ctrl[CTRL_CLK_BIT]) begin
         div_cnt     <= 8'h00;
         link.refclk <= 1'b0;
      end else if (div_cnt == 8'(REFCLK_HALF - 1)) begin
         div_cnt     <= 8'h00;
         link.refclk <= ~link.refclk;
      end else begin
         div_cnt     <= div_cnt + 8'h01;
      end
   end

   // ----------------------------------------------------------------
   // serial port access, four-phase handshake
   // ----------------------------------------------------------------
   always_ff @(posedge clk_i) begin
      if (!rst_n_i || ctrl[CTRL_ABORT_BIT]) begin
         hstate    <= HSQ_H_IDLE;
         link.req  <= 1'b0;
         busy      <= 1'b0;
         if (!rst_n_i) begin
            done       <= 1'b0;
            rdata      <= 8'h00;
            link.we    <= 1'b0;
            link.addr  <= 8'h00;
            link.wdata <= 8'h00;
         end
      end else begin
         case (hstate)
            HSQ_H_IDLE: begin
               if (take && avs_write_i && avs_address_i == HST_CMD) begin
                  link.addr  <= avs_writedata_i[7:0];
                  link.wdata <= avs_writedata_i[15:8];
                  link.we    <= avs_writedata_i[CMD_WE_BIT];
                  busy       <= 1'b1;
                  done       <= 1'b0;
                  hstate     <= HSQ_H_SETUP;
               end
            end
            // data lead the request by one cycle
            HSQ_H_SETUP: begin
               link.req <= 1'b1; // [RULE_08] [RULE_11]
               hstate   <= HSQ_H_WAIT;
            end
            HSQ_H_WAIT: begin
               if (ack_s) begin
                  hstate <= HSQ_H_CAPT;
               end
            end
            HSQ_H_CAPT: begin
               rdata    <= rdata_s;
               link.req <= 1'b0;
               hstate   <= HSQ_H_REL;
            end
            HSQ_H_REL: begin
               if (!ack_s) begin
                  busy   <= 1'b0;
                  done   <= 1'b1;
                  hstate <= HSQ_H_IDLE;
               end
            end
            default: hstate <= HSQ_H_IDLE;
         endcase
      end
   end

endmodule
`default_nettype wire

// *** logic/hsq_device.sv ***
// Overview of operation
// [RULE_01] standby: regulators, pll, core off, nothing kept
// [RULE_02] reset held low at least 100us
// [RULE_03] reset disables ports, clears all state
// [RULE_04] load rom defaults during initialization
// [RULE_05] init: regulator on, latch straps, timed exit
// [RULE_06] serial port silent during initialization
// [RULE_07] wait stage until clock valid, skipped if present
// [RULE_08] host may write configuration during configuration
// [RULE_09] hold low: leave configuration at time-out
// [RULE_10] hold high: stay until host clears it
// [RULE_11] connect passes or waits for handshake
// [RULE_12] handshake connects upstream within connect time
// [RULE_13] communication stage until reset goes low
// [RULE_14] no serial access in communication stage
// [RULE_15] unwritten registers keep their defaults
// [RULE_16] multi mode: one translator per port
// [RULE_17] single mode: one shared translator
// [RULE_18] translator buffer partition sizes fixed
// [RULE_19] reset low standby, high hub mode
// [RULE_20] interrupt pin level picks clock table
// [RULE_21] time-out counts from entry, hold suspends
//
// Chosen here: the Avalon-MM interface to the registers and the register offsets.
`timescale 1ns/1ps
`default_nettype none
module hsq_device
   import hsq_pkg::*;
#(
   parameter int   INIT_CYCLES   = INIT_CYC,
   parameter int   CONFIG_CYCLES = CONFIG_CYC,
   parameter int   CONN_CYCLES   = CONNECT_CYC,
   parameter int   PORTS         = TT_PORTS,
   parameter logic HOLD_DEFAULT  = 1'b0
)(
   input  wire logic       clk_i,
   input  wire logic       rst_n_i,
   hsq_link_if.device      link,
   input  wire logic [1:0] ref_sel_i,
   output var  logic [2:0] stage_o,
   output var  logic       regulators_on_o,
   output var  logic       pll_run_o,
   output var  logic       ports_enabled_o,
   output var  logic       upstream_connect_o,
   output var  logic       ref_secondary_o,
   output var  logic [1:0] ref_sel_o,
   output var  logic       single_tt_o,
   output var  logic [1:0] tt_count_o
);

   localparam int NPIN = 23;

   logic [NPIN-1:0] pin_raw;
   logic [NPIN-1:0] pin_meta;
   logic [NPIN-1:0] pin_s;
   logic            reset_n_s;
   logic            refclk_s;
   logic            int_n_s;
   logic            req_s;
   logic            we_s;
   logic [7:0]      addr_s;
   logic [7:0]      wdata_s;
   logic [1:0]      ref_sel_s;
   logic            hub_rst;
   logic            refclk_q;
   logic [3:0]      lock_cnt;
   logic [6:0]      gap_cnt;
   logic            locked;
   hsq_stage_t      stage;
   hsq_stage_t      next_stage;
   logic [24:0]     timer;
   logic [7:0]      conn_cnt;
   logic            hold_seen;
   logic            go_seen;
   logic [7:0]      cfg_mem [CFG_COUNT];
   logic [7:0]      interlock;
   logic [7:0]      portable_hub_config;
   logic            serve;
   logic            init_done;

   function automatic logic is_cfg(input logic [7:0] a);
      return a < 8'(REG_CFG_BASE + CFG_COUNT);
   endfunction

   // arbitrary customer defaults
   function automatic logic [7:0] rom_default(input int i);
      return ROM_SEED ^ 8'(i);
   endfunction

   // ----------------------------------------------------------------
   // pin synchronisers
   // ----------------------------------------------------------------
   assign pin_raw = {link.reset_n, link.refclk, link.int_n, link.req,
                     link.we, link.addr, link.wdata, ref_sel_i};

   for (genvar g = 0; g < NPIN; g++) begin : g_sync
      always_ff @(posedge clk_i) begin
         if (!rst_n_i) begin
            pin_meta[g] <= 1'b0;
            pin_s[g]    <= 1'b0;
         end else begin
            pin_meta[g] <= pin_raw[g];
            pin_s[g]    <= pin_meta[g];
         end
      end
   end

   assign {reset_n_s, refclk_s, int_n_s, req_s, we_s, addr_s, wdata_s,
           ref_sel_s} = pin_s;
   assign hub_rst   = !rst_n_i || !reset_n_s; // [RULE_19] [RULE_03]
   assign init_done = timer >= 25'(INIT_CYCLES - 1);
   assign link.int_n_dev_oe = 1'b0;

   // ----------------------------------------------------------------
   // reference clock presence, stands in for pll lock
   // ----------------------------------------------------------------
   always_ff @(posedge clk_i) begin
      if (hub_rst) begin
         refclk_q <= 1'b0;
         lock_cnt <= 4'h0;
         gap_cnt  <= 7'h00;
         locked   <= 1'b0; // [RULE_03]
      end else begin
         refclk_q <= refclk_s;
         if (refclk_s && !refclk_q) begin
            gap_cnt <= 7'h00;
            if (lock_cnt == 4'(REF_LOCK_EDGES - 1)) begin
               locked <= 1'b1;
            end else begin
               lock_cnt <= lock_cnt + 4'h1;
            end
         end else if (gap_cnt == 7'(REF_LOSS_CYC - 1)) begin
            lock_cnt <= 4'h0;
            locked   <= 1'b0;
         end else begin
            gap_cnt <= gap_cnt + 7'h01;
         end
      end
   end

   // ----------------------------------------------------------------
   // stage sequencer
   // ----------------------------------------------------------------
   always_comb begin
      next_stage = stage;
      case (stage)
         HSQ_STANDBY: next_stage = HSQ_INIT;
         HSQ_INIT: begin
            if (init_done) begin // [RULE_05]
               next_stage = locked ? HSQ_CONFIG : HSQ_WAITREF; // [RULE_07]
            end
         end
         HSQ_WAITREF: begin
            if (locked) begin // [RULE_07]
               next_stage = HSQ_CONFIG;
            end
         end
         HSQ_CONFIG: begin
            if (!interlock[ILK_HOLD_BIT] &&
                (hold_seen || timer >= 25'(CONFIG_CYCLES - 1))) begin
               next_stage = HSQ_CONNECT; // [RULE_09] [RULE_10] [RULE_21]
            end
         end
         HSQ_CONNECT: begin
            if (!portable_hub_config[PORTABLE_HUB_CONFIG_WAIT_BIT] ||
                (go_seen && conn_cnt >= 8'(CONN_CYCLES - 1))) begin
               next_stage = HSQ_COMM; // [RULE_11] [RULE_12]
            end
         end
         HSQ_COMM: next_stage = HSQ_COMM; // [RULE_13]
         default:  next_stage = HSQ_STANDBY;
      endcase
   end

   always_ff @(posedge clk_i) begin
      if (hub_rst) begin
         stage <= HSQ_STANDBY; // [RULE_01]
         timer <= 25'h000_0000;
      end else begin
         stage <= next_stage;
         // restarts on every stage entry
         if (next_stage != stage) begin
            timer <= 25'h000_0000; // [RULE_21]
         end else if (timer != '1) begin
            timer <= timer + 25'h000_0001;
         end
      end
   end

   always_ff @(posedge clk_i) begin
      if (hub_rst || stage != HSQ_CONNECT || !go_seen) begin
         conn_cnt <= 8'h00;
      end else if (conn_cnt != 8'hFF) begin
         conn_cnt <= conn_cnt + 8'h01; // [RULE_12]
      end
   end

   always_ff @(posedge clk_i) begin
      if (hub_rst) begin
         hold_seen <= 1'b0;
      end else if (stage == HSQ_CONFIG && interlock[ILK_HOLD_BIT]) begin
         hold_seen <= 1'b1; // [RULE_10]
      end
   end

   // ----------------------------------------------------------------
   // serial slave port
   // ----------------------------------------------------------------
   // only configuration and connect answer; earlier requests stay pending
   assign serve = req_s && !link.ack && // [RULE_14]
                  (stage == HSQ_CONFIG || stage == HSQ_CONNECT); // [RULE_06]

   always_ff @(posedge clk_i) begin
      if (hub_rst) begin
         link.ack   <= 1'b0;
         link.rdata <= 8'h00;
      end else if (serve) begin
         link.ack <= 1'b1;
         if (is_cfg(addr_s)) begin
            link.rdata <= cfg_mem[addr_s[3:0]];
         end else if (addr_s == REG_INTERLOCK) begin
            link.rdata <= interlock;
         end else if (addr_s == REG_PORTABLE) begin
            link.rdata <= portable_hub_config;
         end else if (addr_s == REG_STAGE) begin
            link.rdata <= {5'h00, stage};
         end else begin
            link.rdata <= 8'h00;
         end
      end else if (!req_s) begin
         link.ack <= 1'b0;
      end
   end

   always_ff @(posedge clk_i) begin
      if (hub_rst) begin
         for (int i = 0; i < CFG_COUNT; i++) begin
            cfg_mem[i] <= rom_default(i); // [RULE_03] [RULE_04]
         end
         interlock <= {7'h00, HOLD_DEFAULT}; // [RULE_10]
         portable_hub_config      <= PORTABLE_HUB_CONFIG_DEFAULT;
         go_seen   <= 1'b0;
      end else if (serve && we_s) begin
         // untouched entries keep defaults
         if (is_cfg(addr_s)) begin
            cfg_mem[addr_s[3:0]] <= wdata_s; // [RULE_08] [RULE_15]
         end else if (addr_s == REG_INTERLOCK) begin
            interlock <= {6'h00, 1'b0, wdata_s[ILK_HOLD_BIT]};
            if (wdata_s[ILK_GO_BIT] && stage == HSQ_CONNECT) begin
               go_seen <= 1'b1; // [RULE_11]
            end
         end else if (addr_s == REG_PORTABLE) begin
            portable_hub_config <= wdata_s;
         end
      end
   end

   // ----------------------------------------------------------------
   // outputs
   // ----------------------------------------------------------------
   assign stage_o = stage;

   always_ff @(posedge clk_i) begin
      if (hub_rst) begin
         regulators_on_o    <= 1'b0; // [RULE_01]
         pll_run_o          <= 1'b0;
         ports_enabled_o    <= 1'b0; // [RULE_03]
         upstream_connect_o <= 1'b0;
         single_tt_o        <= 1'b0;
         tt_count_o         <= 2'(PORTS);
      end else begin
         regulators_on_o    <= 1'b1; // [RULE_05]
         pll_run_o          <= 1'b1;
         ports_enabled_o    <= next_stage == HSQ_COMM; // [RULE_13]
         upstream_connect_o <= next_stage == HSQ_COMM; // [RULE_12]
         single_tt_o        <= portable_hub_config[PORTABLE_HUB_CONFIG_SINGLE_BIT]; // [RULE_17]
         // one buffer of TT_PERIODIC_BYTES + TT_NONPER_BYTES per translator
         tt_count_o <= portable_hub_config[PORTABLE_HUB_CONFIG_SINGLE_BIT] ? 2'h1 // [RULE_18]
                                             : 2'(PORTS); // [RULE_16]
      end
   end

   // straps are caught once, at the end of initialization
   always_ff @(posedge clk_i) begin
      if (hub_rst) begin
         ref_secondary_o <= 1'b0;
         ref_sel_o       <= 2'h0;
      end else if (stage == HSQ_INIT && init_done) begin
         ref_secondary_o <= ~int_n_s; // [RULE_20]
         ref_sel_o       <= ref_sel_s; // [RULE_05]
      end
   end

endmodule
`default_nettype wire

// *** test/hsq_link_sva.sv ***
`timescale 1ns/1ps
`default_nettype none
module hsq_link_sva
   import hsq_pkg::*;
#(
   parameter int INIT_CYCLES = INIT_CYC
)(
   input wire logic       clk_i,
   input wire logic       rst_n_i,
   input wire logic       reset_n,
   input wire logic       req,
   input wire logic       we,
   input wire logic [7:0] addr,
   input wire logic [7:0] wdata,
   input wire logic       ack,
   input wire logic [2:0] stage_o
);
   localparam int CONN_WIN = 16;
   int unsigned   init_len;

   default clocking @(posedge clk_i); endclocking
   default disable iff (!rst_n_i);

   always_ff @(posedge clk_i) begin
      if (!rst_n_i || stage_o != HSQ_INIT) begin
         init_len <= 0;
      end else begin
         init_len <= init_len + 1;
      end
   end

   a_ack_after_req: assert property (
      $rose(ack) |-> $past(req, 2)) else $error("ack without request");
   a_ack_release: assert property (
      $fell(req) |-> ##[1:8] !ack) else $error("ack held too long");
   a_standby_entry: assert property (
      !reset_n [*4] |=> stage_o == HSQ_STANDBY) else $error("no standby");
   a_silent_early: assert property (
      stage_o inside {HSQ_INIT, HSQ_WAITREF} |-> !ack)
      else $error("answer before configuration");
   a_comm_sticky: assert property (
      stage_o == HSQ_COMM |=> stage_o inside {HSQ_COMM, HSQ_STANDBY})
      else $error("left communication stage");
   a_stage_order: assert property (
      $changed(stage_o) |-> stage_o == HSQ_STANDBY ||
      {$past(stage_o), stage_o} inside
      {6'h01, 6'h0B, 6'h0A, 6'h1A, 6'h16, 6'h37})
      else $error("illegal stage step");
   a_init_length: assert property (
      $past(stage_o) == HSQ_INIT &&
      !(stage_o inside {HSQ_INIT, HSQ_STANDBY}) |->
      init_len inside {[INIT_CYCLES - 1:INIT_CYCLES + 1]})
      else $error("init stage length off");
   a_connect_time: assert property (
      $rose(ack) && we && addr == REG_INTERLOCK && wdata[ILK_GO_BIT] &&
      stage_o == HSQ_CONNECT |-> ##[1:CONN_WIN] stage_o == HSQ_COMM)
      else $error("connect too slow");

   c_waitref: cover property (stage_o == HSQ_WAITREF);
   c_comm: cover property (stage_o == HSQ_COMM);
   c_write: cover property ($rose(ack) && we);
endmodule
`default_nettype wire

// *** test/hub_stage_sequencer_tb.sv ***
`timescale 1ns/1ps
`default_nettype none
module hub_stage_sequencer_tb;
   import hsq_pkg::*;
   localparam int INIT_N = 400;
   localparam int CFG_N  = 200;

   logic        clk_i    = 1'b0;
   logic        rst_n_i  = 1'b0;
   logic [1:0]  av_addr  = 2'h0;
   logic        av_rd    = 1'b0;
   logic        av_wr    = 1'b0;
   logic [31:0] av_wdata = 32'h0;
   logic [31:0] av_rdata;
   logic        av_wait;
   logic [1:0]  ref_sel  = 2'h2;
   logic [2:0]  stage;
   logic [1:0]  sel_q, tt_cnt;
   logic        reg_on, pll_on, ports_on, up_on, ref_sec, single_tt;
   int          errors    = 0;
   int          cmp_count = 0;
   int          cfg_len   = 0;
   logic        saw_wait  = 1'b0;

   initial forever #2.5 clk_i = ~clk_i;

   hsq_link_if link ();
   hsq_host i_hsq_host (.clk_i(clk_i), .rst_n_i(rst_n_i),
      .avs_address_i(av_addr), .avs_read_i(av_rd), .avs_write_i(av_wr),
      .avs_writedata_i(av_wdata), .avs_readdata_o(av_rdata),
      .avs_waitrequest_o(av_wait), .link(link));
   hsq_device #(.INIT_CYCLES(INIT_N), .CONFIG_CYCLES(CFG_N),
      .CONN_CYCLES(5)) i_hsq_device (.clk_i(clk_i), .rst_n_i(rst_n_i),
      .link(link), .ref_sel_i(ref_sel), .stage_o(stage),
      .regulators_on_o(reg_on), .pll_run_o(pll_on),
      .ports_enabled_o(ports_on), .upstream_connect_o(up_on),
      .ref_secondary_o(ref_sec), .ref_sel_o(sel_q),
      .single_tt_o(single_tt), .tt_count_o(tt_cnt));
   hsq_link_sva #(.INIT_CYCLES(INIT_N)) i_hsq_link_sva (.clk_i(clk_i),
      .rst_n_i(rst_n_i), .reset_n(link.reset_n), .req(link.req),
      .we(link.we), .addr(link.addr), .wdata(link.wdata),
      .ack(link.ack), .stage_o(stage));

   // config residence and whether the clock wait was visited
   always @(posedge clk_i) begin
      cfg_len  <= (stage == HSQ_STANDBY) ? 0 : cfg_len + (stage == HSQ_CONFIG);
      saw_wait <= (stage == HSQ_WAITREF) || (saw_wait && stage != HSQ_STANDBY);
   end

   task automatic summarize();
      $display("compares %0d errors %0d", cmp_count, errors);
      if (errors == 0 && cmp_count > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask

   task automatic give_up();
      errors++;
      summarize();
   endtask

   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      cmp_count++;
      if (seen !== exp) begin
         errors++;
         $display("unexpected at %0t: got %h want %h", $time, seen, exp);
      end
   endtask

   // holds the request until waitrequest is seen low at an edge
   task automatic av(input logic w, input logic [1:0] a,
                     input logic [31:0] d, output logic [31:0] q);
      int n;
      @(posedge clk_i);
      av_addr  <= a;
      av_wr    <= w;
      av_rd    <= !w;
      av_wdata <= d;
      n = 0;
      do begin
         @(posedge clk_i);
         n++;
      end while (av_wait !== 1'b0 && n < 50);
      if (n >= 50) give_up();
      q = av_rdata;
      av_rd <= 1'b0;
      av_wr <= 1'b0;
   endtask

   task automatic cmd(input logic w, input logic [7:0] a, input logic [7:0] d);
      logic [31:0] s;
      av(1'b1, HST_CMD, {15'h0, w, d, a}, s);
   endtask

   task automatic finish_xfer(output logic [7:0] q);
      logic [31:0] s;
      int n;
      n = 0;
      do begin
         av(1'b0, HST_STAT, 32'h0, s);
         n++;
      end while (s[0] !== 1'b0 && n < 200);
      if (n >= 200) give_up();
      q = s[15:8];
   endtask

   task automatic xfer(input logic w, input logic [7:0] a,
                       input logic [7:0] d, output logic [7:0] q);
      cmd(w, a, d);
      finish_xfer(q);
   endtask

   task automatic wait_stage(input logic [2:0] s, input int lim);
      int n;
      n = 0;
      while (stage !== s && n < lim) begin
         @(negedge clk_i);
         n++;
      end
      if (stage !== s) give_up();
   endtask

   task automatic standby_check();
      repeat (6) @(posedge clk_i);
      check(stage, HSQ_STANDBY);
      check({reg_on, pll_on, ports_on, up_on}, 4'h0);
   endtask

   // strap low, clock late, hold never written
   task automatic boot_one();
      logic [31:0] s;
      logic [7:0]  q;
      av(1'b1, HST_CTRL, 32'h3, s);
      wait_stage(HSQ_INIT, 20);
      check({reg_on, pll_on}, 2'h3);
      cmd(1'b0, REG_CFG_BASE, 8'h00);
      wait_stage(HSQ_WAITREF, 600);
      @(posedge clk_i);
      ref_sel <= 2'h1;
      av(1'b0, HST_STAT, 32'h0, s);
      check(s[0], 1'b1);
      av(1'b1, HST_CTRL, 32'h5, s);
      wait_stage(HSQ_CONFIG, 600);
      finish_xfer(q);
      check(q, ROM_SEED);
      check({ref_sec, sel_q}, 3'h6);
      xfer(1'b1, 8'h01, 8'h3C, q);
      xfer(1'b0, 8'h01, 8'h00, q);
      check(q, 8'h3C);
      wait_stage(HSQ_COMM, 400);
      check(cfg_len inside {[CFG_N - 1:CFG_N + 2]}, 1'b1);
      check({ports_on, up_on, single_tt, tt_cnt}, 5'h1B);
      repeat (50) @(posedge clk_i);
      check(stage, HSQ_COMM);
      check(TT_PERIODIC_BYTES, 32'h0000_05E8);
      check(TT_NONPER_BYTES, 32'h0000_0110);
   endtask

   // clock present early, hold and handshake used
   task automatic boot_two();
      logic [31:0] s;
      logic [7:0]  q;
      av(1'b1, HST_CTRL, 32'h4, s);
      repeat (20) @(posedge clk_i);
      // a request in standby stays unanswered until aborted
      cmd(1'b0, REG_STAGE, 8'h00);
      repeat (20) @(posedge clk_i);
      av(1'b0, HST_STAT, 32'h0, s);
      check(s[1:0], 2'h1);
      av(1'b1, HST_CTRL, 32'hC, s);
      av(1'b0, HST_STAT, 32'h0, s);
      check(s[0], 1'b0);
      av(1'b0, HST_CTRL, 32'h0, s);
      check(s, 32'h4);
      repeat (20000) @(posedge clk_i);
      standby_check();
      av(1'b1, HST_CTRL, 32'h5, s);
      wait_stage(HSQ_CONFIG, 600);
      check({saw_wait, ref_sec}, 2'h0);
      xfer(1'b0, 8'h01, 8'h00, q);
      check(q, ROM_SEED ^ 8'h01);
      xfer(1'b1, REG_INTERLOCK, 8'h01, q);
      xfer(1'b1, REG_PORTABLE, 8'h03, q);
      repeat (300) @(posedge clk_i);
      check(stage, HSQ_CONFIG);
      xfer(1'b1, REG_INTERLOCK, 8'h00, q);
      wait_stage(HSQ_CONNECT, 20);
      xfer(1'b0, REG_STAGE, 8'h00, q);
      check(q, HSQ_CONNECT);
      check({single_tt, tt_cnt}, 3'h5);
      xfer(1'b1, REG_INTERLOCK, 8'h02, q);
      wait_stage(HSQ_COMM, 20);
      check({ports_on, up_on}, 2'h3);
   endtask

   initial begin
      repeat (16) @(posedge clk_i);
      rst_n_i <= 1'b1;
      standby_check();
      boot_one();
      boot_two();
      summarize();
   end
endmodule
`default_nettype wire
